// >>> include/lfs_map.svh
// Purpose: Named constants for the lubrication fault supervisor.
// Assumes: Included by every design file that needs a figure.
// Notes:   Times are kept in their own unit; cycle counts derive from them.
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

// ----------------------------------------------------------------
// Clock and time base
// ----------------------------------------------------------------
`define LFS_CLK_PERIOD_NS   10
`define LFS_SECOND_NS       1000000000
`define LFS_SEC_PER_MIN     6'h3C
`define LFS_MIN_PER_TENTH   3'h6

// ----------------------------------------------------------------
// Block operation
// ----------------------------------------------------------------
`define LFS_RUNS_MAX        2'h3
`define LFS_BLK_PAUSE_1     12'h006
`define LFS_BLK_PAUSE_2     12'h00C
`define LFS_BLK_PAUSE_3     12'h00F
`define LFS_PAUSE_TENTH_1   8'h01
`define LFS_PAUSE_TENTH_2   8'h02

// ----------------------------------------------------------------
// Fault-hours counting, six BCD digits of tenths of an hour
// ----------------------------------------------------------------
`define LFS_DIGITS          6
`define LFS_DIGIT_W         4
`define LFS_BCD_W           24
`define LFS_BCD_MAX         24'h999999
`define LFS_BCD_ONE         24'h000001
`define LFS_BCD_ZERO        24'h000000
`define LFS_DIGIT_NINE      5'h09
`define LFS_DIGIT_ADJ       5'h06
`define LFS_GROUP_W         12

`endif

// >>> include/lfs_pkg.sv
// Purpose: Types shared by the lubrication fault supervisor files.
// Assumes: lfs_map.svh supplies the widths.
// Notes:   Constants live in the map header, types live here.
`include "lfs_map.svh"

package lfs_pkg;

   typedef logic [`LFS_BCD_W-1:0] lfs_bcd6_t;

   typedef enum logic [1:0] {
      LFS_PAUSE,
      LFS_RUN,
      LFS_BLOCK_PAUSE,
      LFS_FAULT
   } lfs_state_t;

   typedef struct packed {
      logic [`LFS_GROUP_W-1:0] upper;
      logic [`LFS_GROUP_W-1:0] lower;
   } lfs_disp_t;

endpackage : lfs_pkg

// >>> design/lfs_tick_gen.sv
// Purpose: Minute and tenth-hour enable pulses from the system clock.
// Assumes: SEC_CYCLES is the number of clock cycles in one second.
// Notes:   A restart pulse clears the whole chain so an interval starts whole.
`include "lfs_map.svh"

module lfs_tick_gen
   import lfs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `LFS_SECOND_NS / `LFS_CLK_PERIOD_NS
) (
   input  wire logic core_clk,
   input  wire logic rstSync_n,
   input  wire logic restart,
   output logic      minTick,
   output logic      tenthTick
);

   localparam int SW = $clog2(SEC_CYCLES + 1);

   logic [SW-1:0] secCnt_r,  secCnt_nxt;
   logic [5:0]    secOfMin_r, secOfMin_nxt;
   logic [2:0]    minOfTen_r, minOfTen_nxt;
   logic          secTick;

   always_comb begin
      secTick      = (secCnt_r == SW'(SEC_CYCLES - 1));
      minTick      = secTick && (secOfMin_r == `LFS_SEC_PER_MIN - 6'h01);
      tenthTick    = minTick && (minOfTen_r == `LFS_MIN_PER_TENTH - 3'h1);
      secCnt_nxt   = secTick ? '0 : SW'(secCnt_r + 1'b1);
      secOfMin_nxt = secOfMin_r;
      minOfTen_nxt = minOfTen_r;
      if (secTick) begin
         secOfMin_nxt = minTick ? 6'h00 : 6'(secOfMin_r + 6'h01);
      end
      if (minTick) begin
         minOfTen_nxt = tenthTick ? 3'h0 : 3'(minOfTen_r + 3'h1);
      end
      if (restart) begin
         secCnt_nxt   = '0;
         secOfMin_nxt = 6'h00;
         minOfTen_nxt = 3'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         secCnt_r   <= '0;
         secOfMin_r <= 6'h00;
         minOfTen_r <= 3'h0;
      end else begin
         secCnt_r   <= secCnt_nxt;
         secOfMin_r <= secOfMin_nxt;
         minOfTen_r <= minOfTen_nxt;
      end
   end

endmodule : lfs_tick_gen

// >>> design/lfs_bcd_add.sv
// Purpose: Six-digit BCD adder that saturates at all nines.
// Assumes: Both operands hold valid BCD digits.
// Notes:   Purely combinational; the caller registers the sum.
`include "lfs_map.svh"

module lfs_bcd_add
   import lfs_pkg::*;
(
   input  wire lfs_bcd6_t a,
   input  wire lfs_bcd6_t b,
   output lfs_bcd6_t      sum
);

   logic [`LFS_DIGITS:0] carry;
   lfs_bcd6_t            raw;

   assign carry[0] = 1'b0;

   for (genvar i = 0; i < `LFS_DIGITS; i++) begin : g_digit
      logic [4:0] part;
      logic [4:0] fixed;
      assign part  = 5'({1'b0, a[i*`LFS_DIGIT_W +: `LFS_DIGIT_W]})
                   + 5'({1'b0, b[i*`LFS_DIGIT_W +: `LFS_DIGIT_W]})
                   + 5'(carry[i]);
      assign carry[i+1] = (part > `LFS_DIGIT_NINE);
      assign fixed = carry[i+1] ? 5'(part + `LFS_DIGIT_ADJ) : part;
      assign raw[i*`LFS_DIGIT_W +: `LFS_DIGIT_W] = fixed[3:0];
   end

   // Overflow past the top digit pins the reading at its maximum.
   assign sum = carry[`LFS_DIGITS] ? `LFS_BCD_MAX : raw;

endmodule : lfs_bcd_add

// >>> design/lfs_fault_supervisor.sv
// Purpose: Block-operation retry sequence and fault-time recording for a
//          lubrication pump with a piston detector on a progressive system.
// Assumes: core_clk at 100 MHz; piston and acknowledge inputs come from pins.
// Notes:   The fault-hours accumulator has no reset so it outlives rst_n.
`include "lfs_map.svh"

// Function
// RQ1 - The time from raising a fault to its acknowledgment is counted in a fault-state counter.
// RQ2 - On acknowledgment the fault-state count is added into the fault-hours accumulator by itself.
// RQ3 - The accumulator holds the sum of all fault-state intervals over the life of the unit.
// RQ4 - With fault hours selected the display shows the accumulator as two groups of three digits.
// RQ5 - The reading reaches up to 99 999.9 hours.
// RQ6 - Counting resolution is one tenth of an hour and shorter residues are dropped.
// RQ7 - Nothing clears the accumulator, not even a reset.
// RQ8 - A pump run with no piston pulse interrupts normal operation and starts a watched block pause.
// RQ9 - A block pause with no piston pulse is followed by another pump run in block operation.
// RQ10 - A piston pulse during block operation ends it at once and restarts the normal cycle with a pause.
// RQ11 - Three silent runs and two silent block pauses end block operation with the cycle-switch fault.
// RQ12 - Block pause is 6 min for a 0.1 h pause, 12 min for 0.2 h and 15 min for 0.3 h or longer.
// RQ13 - A raised fault halts the normal sequence, is stored and is shown on the indicator and display.
// RQ14 - A prescaled tenth-hour tick advances the fault-state counter while a fault is pending.
// RQ15 - After the cycle-switch fault the pump stays off and the fault stays latched until acknowledged.
module lfs_fault_supervisor
   import lfs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = `LFS_SECOND_NS / `LFS_CLK_PERIOD_NS
) (
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   input  wire logic       pistonPin,
   input  wire logic       ackPin,
   input  wire logic       faultHoursSel,
   input  wire logic [7:0] lubricationPauseTime,
   input  wire logic [7:0] pumpRunTime,
   output logic            pumpOn,
   output logic            faultLed,
   output logic            cycleSwitchFaultCode,
   output logic            blockActive,
   output lfs_disp_t       display
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic [1:0] rstPipe_r;
   logic       rstSync_n;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rstPipe_r <= 2'h0;
      end else begin
         rstPipe_r <= {rstPipe_r[0], 1'b1};
      end
   end
   assign rstSync_n = rstPipe_r[1];

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   // A level is accepted only when the second and third stages agree, so a
   // single-cycle glitch caught on a slow edge never counts as a pulse.
   logic [1:0] pinIn;
   logic [1:0] stg1_r, stg2_r, stg3_r, level_r, levelPrev_r;
   logic [1:0] level_nxt;
   logic [1:0] rise;

   assign pinIn = {ackPin, pistonPin};

   for (genvar i = 0; i < 2; i++) begin : g_sync
      always_comb begin
         level_nxt[i] = (stg2_r[i] == stg3_r[i]) ? stg3_r[i] : level_r[i];
      end

      always_ff @(posedge core_clk or negedge rstSync_n) begin
         if (!rstSync_n) begin
            stg1_r[i]      <= 1'b0;
            stg2_r[i]      <= 1'b0;
            stg3_r[i]      <= 1'b0;
            level_r[i]     <= 1'b0;
            levelPrev_r[i] <= 1'b0;
         end else begin
            stg1_r[i]      <= pinIn[i];
            stg2_r[i]      <= stg1_r[i];
            stg3_r[i]      <= stg2_r[i];
            level_r[i]     <= level_nxt[i];
            levelPrev_r[i] <= level_r[i];
         end
      end

      assign rise[i] = level_r[i] && !levelPrev_r[i];
   end

   logic pistonSeen;
   logic ackSeen;
   assign pistonSeen = rise[0];
   assign ackSeen    = rise[1];

   // ----------------------------------------------------------------
   // Time base
   // ----------------------------------------------------------------
   logic minTick;
   logic tenthTick;
   logic faultEntry;

   // RQ14 prescaled tenth tick
   lfs_tick_gen #(
      .SEC_CYCLES (SEC_CYCLES)
   ) u_tick (
      .core_clk  (core_clk),
      .rstSync_n (rstSync_n),
      .restart   (faultEntry),
      .minTick   (minTick),
      .tenthTick (tenthTick)
   );

   // ----------------------------------------------------------------
   // Lubrication and block-operation sequence
   // ----------------------------------------------------------------
   lfs_state_t  state_r,   state_nxt;
   logic [11:0] timer_r,   timer_nxt;
   logic [1:0]  runs_r,    runs_nxt;
   logic        pulsed_r,  pulsed_nxt;
   logic [11:0] pauseLen;
   logic [11:0] blockLen;
   logic [11:0] limit;
   logic        expired;

   always_comb begin
      pauseLen = 12'(lubricationPauseTime) * 12'(`LFS_MIN_PER_TENTH);
      // RQ12 block pause length
      if (lubricationPauseTime <= `LFS_PAUSE_TENTH_1) begin
         blockLen = `LFS_BLK_PAUSE_1;
      end else if (lubricationPauseTime == `LFS_PAUSE_TENTH_2) begin
         blockLen = `LFS_BLK_PAUSE_2;
      end else begin
         blockLen = `LFS_BLK_PAUSE_3;
      end
      case (state_r)
         LFS_PAUSE:       limit = pauseLen;
         LFS_RUN:         limit = 12'(pumpRunTime);
         LFS_BLOCK_PAUSE: limit = blockLen;
         default:         limit = 12'h000;
      endcase
      expired = (timer_r >= limit);
   end

   always_comb begin
      state_nxt  = state_r;
      timer_nxt  = minTick ? 12'(timer_r + 12'h001) : timer_r;
      runs_nxt   = runs_r;
      pulsed_nxt = pulsed_r || pistonSeen;
      faultEntry = 1'b0;
      case (state_r)
         LFS_PAUSE: begin
            if (expired) begin
               state_nxt  = LFS_RUN;
               timer_nxt  = 12'h000;
               pulsed_nxt = 1'b0;
            end
         end
         LFS_RUN: begin
            if (pistonSeen && runs_r != 2'h0) begin
               // RQ10 abort block operation
               state_nxt = LFS_PAUSE;
               timer_nxt = 12'h000;
               runs_nxt  = 2'h0;
            end else if (expired) begin
               timer_nxt = 12'h000;
               if (pulsed_nxt) begin
                  state_nxt = LFS_PAUSE;
                  runs_nxt  = 2'h0;
               end else if (2'(runs_r + 2'h1) == `LFS_RUNS_MAX) begin
                  // RQ11 raise cycle-switch fault
                  state_nxt  = LFS_FAULT;
                  runs_nxt   = 2'h0;
                  faultEntry = 1'b1;
               end else begin
                  // RQ8 silent run, block pause
                  state_nxt = LFS_BLOCK_PAUSE;
                  runs_nxt  = 2'(runs_r + 2'h1);
               end
            end
         end
         LFS_BLOCK_PAUSE: begin
            if (pistonSeen) begin
               // RQ10 abort block operation
               state_nxt = LFS_PAUSE;
               timer_nxt = 12'h000;
               runs_nxt  = 2'h0;
            end else if (expired) begin
               // RQ9 next block run
               state_nxt  = LFS_RUN;
               timer_nxt  = 12'h000;
               pulsed_nxt = 1'b0;
            end
         end
         LFS_FAULT: begin
            // RQ15 hold until acknowledged
            timer_nxt = 12'h000;
            if (ackSeen) begin
               state_nxt = LFS_PAUSE;
            end
         end
         default: begin
            state_nxt = LFS_PAUSE;
            timer_nxt = 12'h000;
            runs_nxt  = 2'h0;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state_r  <= LFS_PAUSE;
         timer_r  <= 12'h000;
         runs_r   <= 2'h0;
         pulsed_r <= 1'b0;
      end else begin
         state_r  <= state_nxt;
         timer_r  <= timer_nxt;
         runs_r   <= runs_nxt;
         pulsed_r <= pulsed_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Fault-state counter and fault-hours accumulator
   // ----------------------------------------------------------------
   lfs_bcd6_t faultCnt_r, faultCnt_nxt;
   lfs_bcd6_t faultInc;
   lfs_bcd6_t accSum;
   lfs_bcd6_t acc_nxt;
   logic      ackTake;
   // RQ7 retained, no reset
   lfs_bcd6_t acc_r = `LFS_BCD_ZERO;

   assign ackTake = (state_r == LFS_FAULT) && ackSeen;

   lfs_bcd_add u_inc (
      .a   (faultCnt_r),
      .b   (`LFS_BCD_ONE),
      .sum (faultInc)
   );

   // RQ5 saturating six-digit sum
   lfs_bcd_add u_acc (
      .a   (acc_r),
      .b   (faultCnt_r),
      .sum (accSum)
   );

   always_comb begin
      faultCnt_nxt = faultCnt_r;
      if (faultEntry) begin
         faultCnt_nxt = `LFS_BCD_ZERO;
      end else if (state_r == LFS_FAULT && tenthTick) begin
         // RQ1 RQ6 whole tenths only
         faultCnt_nxt = faultInc;
      end
      // RQ2 RQ3 add on acknowledgment
      acc_nxt = ackTake ? accSum : acc_r;
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         faultCnt_r <= `LFS_BCD_ZERO;
      end else begin
         faultCnt_r <= faultCnt_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      acc_r <= acc_nxt;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   logic      pumpOn_nxt, faultLed_nxt, blockActive_nxt;
   lfs_disp_t display_nxt;
   lfs_bcd6_t shown;

   always_comb begin
      pumpOn_nxt      = (state_nxt == LFS_RUN);
      // RQ13 stored and shown fault
      faultLed_nxt    = (state_nxt == LFS_FAULT);
      blockActive_nxt = (runs_nxt != 2'h0);
      // RQ4 two groups of three digits
      shown             = faultHoursSel ? acc_nxt : faultCnt_nxt;
      display_nxt.upper = shown[`LFS_BCD_W-1:`LFS_GROUP_W];
      display_nxt.lower = shown[`LFS_GROUP_W-1:0];
   end

   always_ff @(posedge core_clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         pumpOn      <= 1'b0;
         faultLed    <= 1'b0;
         blockActive <= 1'b0;
         display     <= '0;
      end else begin
         pumpOn      <= pumpOn_nxt;
         faultLed    <= faultLed_nxt;
         blockActive <= blockActive_nxt;
         display     <= display_nxt;
      end
   end

   assign cycleSwitchFaultCode = faultLed;

endmodule : lfs_fault_supervisor

// >>> sim/lfs_piston_model.sv
// Purpose: Piston detector on the metering device, seen from the pump side.
// Assumes: While respond is high it answers 20 cycles into every pump run.
// Notes:   The pin rests low between pulses, as a pulled-down input would.
module lfs_piston_model (
   input  wire logic core_clk,
   input  wire logic pumpOn,
   input  wire logic respond,
   input  wire logic kick,
   output logic      pistonPin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] runCnt_r   = 8'h00;
   logic [2:0] pulseCnt_r = 3'h0;

   // Pulses last four cycles so the pin filter cannot drop them.
   always_ff @(posedge core_clk) begin
      runCnt_r <= pumpOn ? runCnt_r + 8'(runCnt_r != 8'hFF) : 8'h00;
      if (kick || (respond && runCnt_r == 8'h14)) begin
         pulseCnt_r <= 3'h4;
      end else if (pulseCnt_r != 3'h0) begin
         pulseCnt_r <= pulseCnt_r - 3'h1;
      end
   end
   assign pistonPin = (pulseCnt_r != 3'h0);
endmodule : lfs_piston_model

// >>> sim/lfs_fault_supervisor_properties.sv
// Purpose: Port-level checks of the block retry sequence and fault timing.
// Assumes: Sees only the ports of the supervisor's top module.
// Notes:   Block pause length allows a short first minute.
module lfs_fault_supervisor_properties
   import lfs_pkg::*;
#(
   parameter int unsigned SEC_CYCLES = 100000000
) (
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic       pistonPin,
   input wire logic       ackPin,
   input wire logic       faultHoursSel,
   input wire logic [7:0] lubricationPauseTime,
   input wire logic [7:0] pumpRunTime,
   input wire logic       pumpOn,
   input wire logic       faultLed,
   input wire logic       cycleSwitchFaultCode,
   input wire logic       blockActive,
   input wire lfs_disp_t  display
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam int unsigned MIN_CYC = 60 * SEC_CYCLES;
   logic [2:0]  postRst_r;
   logic [3:0]  ackAge_r;
   logic [31:0] blkCnt_r;
   logic [31:0] blkMin;
   logic [23:0] dig;
   logic        bcdOk;

   assign blkMin = (lubricationPauseTime <= 8'h01) ? 32'h6 : (lubricationPauseTime == 8'h02) ? 32'hC : 32'hF;
   assign dig    = display;
   assign bcdOk  = dig[23:20] < 4'hA && dig[19:16] < 4'hA && dig[15:12] < 4'hA &&
                   dig[11:8] < 4'hA && dig[7:4] < 4'hA && dig[3:0] < 4'hA;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         postRst_r <= 3'h0;
         ackAge_r  <= 4'hF;
         blkCnt_r  <= 32'h0;
      end else begin
         postRst_r <= postRst_r + 3'(postRst_r != 3'h7);
         ackAge_r  <= ackPin ? 4'h0 : ackAge_r + 4'(ackAge_r != 4'hF);
         blkCnt_r  <= (blockActive && !pumpOn) ? blkCnt_r + 32'h1 : 32'h0;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   a_code_led: assert property (cycleSwitchFaultCode == faultLed)
      else $error("fault code differs from fault indicator");
   a_fault_stops: assert property (faultLed |-> !pumpOn && !blockActive)
      else $error("pump or block flag active during fault");
   a_fault_kept: assert property ($fell(faultLed) |-> ackAge_r <= 4'h9)
      else $error("fault dropped without acknowledge");
   a_fault_entry: assert property ($rose(faultLed) |-> $past(pumpOn) && $past(blockActive))
      else $error("fault raised outside the last block run");
   a_block_entry: assert property ($rose(blockActive) |-> $past(pumpOn) && !pumpOn)
      else $error("block pause not entered from a run");
   a_block_exit: assert property ($fell(blockActive) && !faultLed |-> !pumpOn)
      else $error("abort did not restart with a pause");
   a_block_len: assert property ($rose(pumpOn) && blockActive |->
      blkCnt_r + MIN_CYC >= blkMin * MIN_CYC && blkCnt_r <= blkMin * MIN_CYC + 32'h8)
      else $error("block pause length wrong");
   a_hours_hold: assert property (postRst_r == 3'h7 && faultHoursSel && $past(faultHoursSel)
      && $past(faultHoursSel, 2) && !$fell(faultLed) |-> $stable(display))
      else $error("fault hours changed without acknowledge");
   a_count_clear: assert property ($rose(faultLed) && !faultHoursSel |-> ##[0:2] dig == 24'h0)
      else $error("fault-state counter not cleared at fault");
   a_bcd_valid: assert property (bcdOk)
      else $error("display digit not decimal");
endmodule : lfs_fault_supervisor_properties

bind lfs_fault_supervisor lfs_fault_supervisor_properties #(.SEC_CYCLES(SEC_CYCLES)) u_props (
   .core_clk(core_clk), .rst_n(rst_n), .pistonPin(pistonPin), .ackPin(ackPin),
   .faultHoursSel(faultHoursSel), .lubricationPauseTime(lubricationPauseTime),
   .pumpRunTime(pumpRunTime), .pumpOn(pumpOn), .faultLed(faultLed),
   .cycleSwitchFaultCode(cycleSwitchFaultCode), .blockActive(blockActive), .display(display)
);

// >>> sim/lfs_fault_supervisor_bench.sv
// Purpose: Self-checking bench for the lubrication fault supervisor.
// Assumes: SEC_CYCLES is cut to 2, so a tenth hour is 720 cycles.
// Notes:   Saturation at all nines is never reached; the digit assertion only checks that digits stay decimal.
module lfs_fault_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SEC   = 2;
   localparam int MINC  = 60 * SEC;
   localparam int TENTH = 6 * MINC;
   logic               core_clk             = 1'b0;
   logic               rst_n                = 1'b0;
   logic               ackPin               = 1'b0;
   logic               faultHoursSel        = 1'b0;
   logic               respond              = 1'b1;
   logic               kick                 = 1'b0;
   logic [7:0]         lubricationPauseTime = 8'h01;
   logic [7:0]         pumpRunTime          = 8'h02;
   logic               pistonPin;
   logic               pumpOn;
   logic               faultLed;
   logic               blockActive;
   logic               cycleSwitchFaultCode;
   lfs_pkg::lfs_disp_t display;
   int                 error_cnt = 0;
   int                 n_checks  = 0;
   int                 cycles    = 0;
   int                 accT      = 0;

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   lfs_fault_supervisor #(.SEC_CYCLES(SEC)) uut (
      .core_clk(core_clk), .rst_n(rst_n), .pistonPin(pistonPin), .ackPin(ackPin),
      .faultHoursSel(faultHoursSel), .lubricationPauseTime(lubricationPauseTime),
      .pumpRunTime(pumpRunTime), .pumpOn(pumpOn), .faultLed(faultLed),
      .cycleSwitchFaultCode(cycleSwitchFaultCode), .blockActive(blockActive), .display(display)
   );
   lfs_piston_model u_piston (
      .core_clk(core_clk), .pumpOn(pumpOn), .respond(respond), .kick(kick), .pistonPin(pistonPin)
   );

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 80000) begin
         error_cnt++;
         $display("MISMATCH run_length expected end seen hang");
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic chk_rng(input string what, input int lo, input int hi, input int got);
      n_checks++;
      if (got < lo || got > hi) begin
         error_cnt++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   function automatic logic pick(input int sel);
      return (sel == 0) ? pumpOn : (sel == 1) ? blockActive : faultLed;
   endfunction : pick

   task automatic wait_on(input int sel, input logic lvl, output int n);
      n = 0;
      while (pick(sel) !== lvl && n < 20000) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      chk_rng("wait_bound", 0, 19999, n);
   endtask : wait_on

   task automatic t_normal();
      int n;
      wait_on(0, 1'b1, n);
      wait_on(0, 1'b0, n);
      repeat (40) @(posedge core_clk);
      #1;
      chk("block_after_good_run", 24'h0, 24'(blockActive));
      $display("t_normal done");
   endtask : t_normal

   task automatic t_block(input logic [7:0] tenths, input int mins);
      int n;
      @(posedge core_clk);
      respond <= 1'b0;
      lubricationPauseTime <= tenths;
      wait_on(0, 1'b1, n);
      wait_on(1, 1'b1, n);
      chk("pump_in_block_pause", 24'h0, 24'(pumpOn));
      wait_on(0, 1'b1, n);
      chk_rng("block_pause_cycles", (mins - 1) * MINC, mins * MINC + 8, n);
      chk("block_run_flag", 24'h1, 24'(blockActive));
      @(posedge core_clk);
      kick <= 1'b1;
      @(posedge core_clk);
      kick <= 1'b0;
      wait_on(1, 1'b0, n);
      chk_rng("abort_latency", 0, 12, n);
      chk("pump_after_abort", 24'h0, 24'(pumpOn));
      $display("t_block %0d done", mins);
   endtask : t_block

   task automatic t_fault(input int tenths);
      int   n;
      int   runs;
      int   bps;
      logic prevPump;
      logic held;
      @(posedge core_clk);
      respond <= 1'b0;
      faultHoursSel <= 1'b0;
      lubricationPauseTime <= 8'h01;
      runs = 0;
      bps = 0;
      n = 0;
      prevPump = pumpOn;
      while (faultLed !== 1'b1 && n < 20000) begin
         @(posedge core_clk);
         #1;
         n++;
         if (pumpOn === 1'b1 && prevPump === 1'b0) runs++;
         if (pumpOn === 1'b0 && prevPump === 1'b1 && blockActive === 1'b1) bps++;
         prevPump = pumpOn;
      end
      chk("silent_runs", 24'h3, 24'(runs));
      chk("block_pauses", 24'h2, 24'(bps));
      held = 1'b1;
      repeat (tenths * TENTH + TENTH / 2) begin
         @(posedge core_clk);
         #1;
         if (faultLed !== 1'b1 || pumpOn !== 1'b0 || cycleSwitchFaultCode !== 1'b1) held = 1'b0;
      end
      chk("fault_latched", 24'h1, 24'(held));
      chk("fault_state_count", 24'(tenths), display);
      @(posedge core_clk);
      faultHoursSel <= 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      chk("hours_before_ack", 24'(accT), display);
      @(posedge core_clk);
      ackPin <= 1'b1;
      repeat (4) @(posedge core_clk);
      ackPin <= 1'b0;
      #1;
      wait_on(2, 1'b0, n);
      chk_rng("ack_latency", 0, 12, n);
      accT = accT + tenths;
      chk("hours_after_ack", 24'(accT), display);
      $display("t_fault %0d done", tenths);
   endtask : t_fault

   task automatic t_persist();
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      #1;
      chk("hours_after_reset", 24'(accT), display);
      t_fault(1);
      $display("t_persist done");
   endtask : t_persist

   initial begin
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      t_normal();
      t_block(8'h01, 6);
      t_block(8'h02, 12);
      t_block(8'h03, 15);
      t_block(8'h05, 15);
      t_fault(3);
      t_persist();
      print_verdict();
   end
endmodule : lfs_fault_supervisor_bench
